// ===== hdl/nvp_pkg.sv
// package: register map, field layout and constants for nv access control
package nvp_pkg;
  // wishbone register byte addresses (latch indices are 0..3, so 4*index)
  localparam logic [7:0] NVP_IDX_DRIVE_LOW  = 8'h00;
  localparam logic [7:0] NVP_IDX_DRIVE_HIGH = 8'h01;
  localparam logic [7:0] NVP_IDX_RST_DBG    = 8'h02;
  localparam logic [7:0] NVP_IDX_CLK_ECC    = 8'h03;
  localparam logic [7:0] NVP_ADR_DRIVE_LOW  = 8'h00;
  localparam logic [7:0] NVP_ADR_DRIVE_HIGH = 8'h04;
  localparam logic [7:0] NVP_ADR_RST_DBG    = 8'h08;
  localparam logic [7:0] NVP_ADR_CLK_ECC    = 8'h0C;
  localparam logic [7:0] NVP_ADR_CTRL       = 8'h10;
  localparam logic [7:0] NVP_ADR_STATUS     = 8'h14;
  localparam logic [7:0] NVP_ADR_ROWPROT    = 8'h18;
  localparam logic [7:0] NVP_ADR_EE_ADDR    = 8'h1C;
  localparam logic [7:0] NVP_ADR_EE_DATA    = 8'h20;
  // ctrl register bits
  localparam int NVP_CTRL_CHIP_ERASE = 0;
  localparam int NVP_CTRL_SECURE     = 1;
  localparam int NVP_CTRL_EE_WRITE   = 2;
  localparam int NVP_CTRL_LATCH_COMMIT = 3;
  // flash geometry
  localparam int NVP_ROW_BYTES   = 256;
  localparam int NVP_ECC_BYTES   = 32;
  localparam int NVP_ROWS        = 256;
  localparam int NVP_ROW_AW      = 8;
  // eeprom geometry
  localparam int NVP_EE_ROWS     = 128;
  localparam int NVP_EE_ROW_LEN  = 16;
  localparam int NVP_EE_AW       = 11;
  // latch field positions
  localparam int NVP_F_EXT_RST_EN   = 7;
  localparam int NVP_F_DBG_EN       = 6;
  localparam int NVP_F_ECC_EN       = 3;
  localparam int NVP_F_DBG_PORT_LSB = 1;
  localparam int NVP_F_PHS_LSB   = 4;
  // factory defaults of the latch bytes
  localparam logic [7:0] NVP_RST_DRIVE_LOW  = 8'h00;
  localparam logic [7:0] NVP_RST_DRIVE_HIGH = 8'h00;
  localparam logic [7:0] NVP_RST_RST_DBG    = 8'h40;
  localparam logic [7:0] NVP_RST_CLK_ECC    = 8'h0A;
  // nonvolatile write time
  localparam int NVP_WRITE_MS     = 20;
  localparam int NVP_CLK_HZ       = 10_000_000;
  localparam int NVP_WRITE_CYCLES = NVP_WRITE_MS * (NVP_CLK_HZ / 1000);
  typedef enum logic [1:0] {
    NVP_UNPROT, NVP_FACTORY, NVP_FIELD, NVP_FULL
  } nvp_prot_t;
  typedef enum logic [1:0] {
    NVP_DBG_PORT_JTAG5, NVP_DBG_PORT_JTAG4, NVP_DBG_PORT_SWD, NVP_DBG_PORT_OFF
  } nvp_dbg_port_t;
endpackage : nvp_pkg

// ===== hdl/nvp_top.sv
// nonvolatile access control: flash row protection, eeprom, config latches
`timescale 1ns/100ps
`default_nettype none
module nvp_top
  import nvp_pkg::*;
#(
  parameter int WRITE_CYCLES = nvp_pkg::NVP_WRITE_CYCLES
)(
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // flash access check
  input  wire logic        fl_req_i,
  input  wire logic        fl_ext_i,
  input  wire logic        fl_we_i,
  input  wire logic [15:0] fl_adr_i,
  output logic             fl_grant_o,
  output logic             fl_deny_o,
  // cpu instruction fetch
  input  wire logic        if_req_i,
  input  wire logic        if_eeprom_i,
  output logic             if_grant_o,
  // applied configuration
  output logic [15:0]      port_reset_drive_field_o,
  output logic [1:0]       port15_reset_drive_o,
  output logic             ext_reset_pin_enable_o,
  output logic             debug_access_enable_o,
  output logic [1:0]       debug_port_select_o,
  output logic             ecc_area_enable_o,
  output logic [3:0]       digital_clock_phase_delay_o,
  output logic             nv_busy_o
);
  import nvp_pkg::*;

  localparam int BUSY_W = $clog2(WRITE_CYCLES + 1);

  // flash row protection table
  // nonvolatile state keeps its power-on image; reset never clears it
  logic [1:0]  prot_r    [NVP_ROWS] = '{default: 2'(NVP_UNPROT)};
  logic [1:0]  prot_nxt  [NVP_ROWS];
  logic        erased_r = 1'b0;
  logic        erased_nxt;
  logic        secure_r = 1'b0;
  logic        secure_nxt;
  // eeprom array and row write buffer
  logic [7:0]  ee_r      [NVP_EE_ROWS*NVP_EE_ROW_LEN];
  logic [7:0]  ebuf_r    [NVP_EE_ROW_LEN];
  logic [NVP_EE_AW-1:0] ee_adr_r, ee_adr_nxt;
  logic [6:0]  wr_row_r, wr_row_nxt;
  // latches: stored copy and copy applied at reset
  logic [7:0]  lat_r     [4] = '{NVP_RST_DRIVE_LOW, NVP_RST_DRIVE_HIGH,
                                 NVP_RST_RST_DBG, NVP_RST_CLK_ECC};
  logic [7:0]  lat_nxt   [4];
  logic [7:0]  app_r     [4];
  logic        app_done_r;
  logic [BUSY_W-1:0] busy_r, busy_nxt;
  logic        ee_pend_r, ee_pend_nxt;
  logic        lat_pend_r, lat_pend_nxt;
  logic        ack_r, ack_nxt;
  logic [31:0] dat_r, dat_nxt;
  logic        wr_go, rd_go;
  logic [7:0]  row_sel;
  logic [1:0]  row_lvl;
  logic        allow;

  assign wr_go = wb_cyc_i && wb_stb_i && wb_we_i && !ack_r && wb_sel_i[0];
  assign rd_go = wb_cyc_i && wb_stb_i && !wb_we_i && !ack_r;

  // flash permission check, combinational per request
  assign row_sel = fl_adr_i[15:8];
  assign row_lvl = prot_r[row_sel];
  always_comb
  begin
    unique case (nvp_prot_t'(row_lvl))
      NVP_UNPROT:  allow = 1'b1;
      NVP_FACTORY: allow = !(fl_ext_i && !fl_we_i);
      NVP_FIELD:   allow = !fl_ext_i;
      NVP_FULL:    allow = !fl_ext_i && !fl_we_i;
    endcase
    if (fl_ext_i && secure_r)
      allow = 1'b0;
  end
  assign fl_grant_o = fl_req_i && allow && !(fl_we_i && busy_r != '0);
  assign fl_deny_o  = fl_req_i && !allow;
  // fetch never stalls on an eeprom write; eeprom is never a code source
  assign if_grant_o = if_req_i && !if_eeprom_i;

  // register bus and command decode
  always_comb
  begin
    prot_nxt     = prot_r;
    erased_nxt   = erased_r;
    secure_nxt   = secure_r;
    lat_nxt      = lat_r;
    ee_adr_nxt   = ee_adr_r;
    wr_row_nxt   = wr_row_r;
    busy_nxt     = (busy_r != '0) ? BUSY_W'(busy_r - 1'b1) : busy_r;
    ee_pend_nxt  = ee_pend_r && (busy_r != '0);
    lat_pend_nxt = lat_pend_r && (busy_r != '0);
    dat_nxt      = 32'h0000_0000;
    ack_nxt      = wb_cyc_i && wb_stb_i && !ack_r;
    if (wr_go && busy_r == '0)
    begin
      unique case (wb_adr_i)
        NVP_ADR_DRIVE_LOW:  lat_nxt[NVP_IDX_DRIVE_LOW[1:0]]  = wb_dat_i[7:0];
        NVP_ADR_DRIVE_HIGH: lat_nxt[NVP_IDX_DRIVE_HIGH[1:0]] = wb_dat_i[7:0];
        NVP_ADR_RST_DBG:    lat_nxt[NVP_IDX_RST_DBG[1:0]]    = wb_dat_i[7:0];
        NVP_ADR_CLK_ECC:    lat_nxt[NVP_IDX_CLK_ECC[1:0]]    = wb_dat_i[7:0];
        NVP_ADR_CTRL:
        begin
          if (wb_dat_i[NVP_CTRL_CHIP_ERASE])
          begin
            for (int i = 0; i < NVP_ROWS; i++)
              prot_nxt[i] = 2'(NVP_UNPROT);
            erased_nxt = 1'b1;
            busy_nxt   = BUSY_W'(WRITE_CYCLES);
          end
          if (wb_dat_i[NVP_CTRL_SECURE])
            secure_nxt = 1'b1;
          if (wb_dat_i[NVP_CTRL_EE_WRITE])
          begin
            wr_row_nxt  = ee_adr_r[NVP_EE_AW-1:4];
            ee_pend_nxt = 1'b1;
            busy_nxt    = BUSY_W'(WRITE_CYCLES);
          end
          if (wb_dat_i[NVP_CTRL_LATCH_COMMIT])
          begin
            lat_pend_nxt = 1'b1;
            busy_nxt     = BUSY_W'(WRITE_CYCLES);
          end
        end
        NVP_ADR_ROWPROT:
        begin
          // levels only land while erased_r is set (from a chip erase until a later secure write), and only into a row still unprotected
          if (erased_r && prot_r[wb_dat_i[15:8]] == 2'(NVP_UNPROT))
            prot_nxt[wb_dat_i[15:8]] = wb_dat_i[1:0];
        end
        NVP_ADR_EE_ADDR: ee_adr_nxt = wb_dat_i[NVP_EE_AW-1:0];
        default: ;
      endcase
    end
    if (wr_go && busy_r == '0 && wb_adr_i == NVP_ADR_CTRL && !wb_dat_i[NVP_CTRL_CHIP_ERASE])
      erased_nxt = erased_r && !wb_dat_i[NVP_CTRL_SECURE];
    if (rd_go)
    begin
      unique case (wb_adr_i)
        NVP_ADR_DRIVE_LOW:  dat_nxt[7:0] = lat_r[NVP_IDX_DRIVE_LOW[1:0]];
        NVP_ADR_DRIVE_HIGH: dat_nxt[7:0] = lat_r[NVP_IDX_DRIVE_HIGH[1:0]];
        NVP_ADR_RST_DBG:    dat_nxt[7:0] = lat_r[NVP_IDX_RST_DBG[1:0]];
        NVP_ADR_CLK_ECC:    dat_nxt[7:0] = lat_r[NVP_IDX_CLK_ECC[1:0]];
        NVP_ADR_STATUS:     dat_nxt[3:0] = {ee_pend_r, erased_r, secure_r, busy_r != '0};
        NVP_ADR_ROWPROT:    dat_nxt[1:0] = prot_r[wb_dat_i[15:8]];
        NVP_ADR_EE_ADDR:    dat_nxt[NVP_EE_AW-1:0] = ee_adr_r;
        // direct byte read, raw contents, no correction
        NVP_ADR_EE_DATA:    dat_nxt[7:0] = ee_r[ee_adr_r];
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      // protection, eeprom, latches are nonvolatile: not touched by reset
      ee_adr_r    <= '0;
      wr_row_r    <= '0;
      busy_r      <= '0;
      ee_pend_r   <= 1'b0;
      lat_pend_r  <= 1'b0;
      ack_r       <= 1'b0;
      dat_r       <= 32'h0000_0000;
      app_done_r  <= 1'b0;
    end
    else
    begin
      prot_r     <= prot_nxt;
      erased_r   <= erased_nxt;
      secure_r   <= secure_nxt;
      ee_adr_r   <= ee_adr_nxt;
      wr_row_r   <= wr_row_nxt;
      busy_r     <= busy_nxt;
      ee_pend_r  <= ee_pend_nxt;
      lat_pend_r <= lat_pend_nxt;
      ack_r      <= ack_nxt;
      dat_r      <= dat_nxt;
      app_done_r <= 1'b1;
      if (lat_pend_r && busy_r == BUSY_W'(1))
        lat_r <= lat_nxt;
      else if (busy_r == '0)
        lat_r <= lat_nxt;
    end
  end

  // row buffer fills on data writes; committed when the write time ends
  always_ff @(posedge clk_i)
  begin
    if (wr_go && busy_r == '0 && wb_adr_i == NVP_ADR_EE_DATA)
      ebuf_r[ee_adr_r[3:0]] <= wb_dat_i[7:0];
    if (ee_pend_r && busy_r == BUSY_W'(1))
      for (int i = 0; i < NVP_EE_ROW_LEN; i++)
        ee_r[{wr_row_r, 4'(i)}] <= ebuf_r[i];
  end

  // latch contents take effect only at the release of reset
  always_ff @(posedge clk_i)
  begin
    if (!rst_i && !app_done_r)
      app_r <= lat_r;
  end

  assign port_reset_drive_field_o = {app_r[1], app_r[0]};
  assign port15_reset_drive_o     = app_r[2][1:0];
  assign ext_reset_pin_enable_o   = app_r[2][NVP_F_EXT_RST_EN];
  assign debug_access_enable_o    = app_r[2][NVP_F_DBG_EN] && !secure_r;
  assign debug_port_select_o      = secure_r ? 2'(NVP_DBG_PORT_OFF)
                                             : app_r[3][NVP_F_DBG_PORT_LSB +: 2];
  assign ecc_area_enable_o        = app_r[3][NVP_F_ECC_EN];
  assign digital_clock_phase_delay_o = app_r[3][NVP_F_PHS_LSB +: 4];
  assign nv_busy_o = busy_r != '0;
  assign wb_ack_o  = ack_r;
  assign wb_dat_o  = dat_r;

  property p_ack_one;
    @(posedge clk_i) disable iff (rst_i)
      (wb_cyc_i && wb_stb_i && !ack_r) |=> ack_r ##1 !ack_r;
  endproperty
  a_ack_one: assert property (p_ack_one) else $error("ack not single cycle");
  property p_ext_read_factory;
    @(posedge clk_i) disable iff (rst_i)
      (fl_req_i && fl_ext_i && !fl_we_i && row_lvl == 2'(NVP_FACTORY)) |-> fl_deny_o;
  endproperty
  a_ext_read_factory: assert property (p_ext_read_factory) else $error("factory ext read");
  property p_field_ext;
    @(posedge clk_i) disable iff (rst_i)
      (fl_req_i && fl_ext_i && row_lvl == 2'(NVP_FIELD)) |-> !fl_grant_o;
  endproperty
  a_field_ext: assert property (p_field_ext) else $error("field ext allowed");
  property p_full_wr;
    @(posedge clk_i) disable iff (rst_i)
      (fl_req_i && fl_we_i && row_lvl == 2'(NVP_FULL)) |-> fl_deny_o;
  endproperty
  a_full_wr: assert property (p_full_wr) else $error("full prot write");
  property p_unprot;
    @(posedge clk_i) disable iff (rst_i)
      (fl_req_i && !secure_r && row_lvl == 2'(NVP_UNPROT)) |-> !fl_deny_o;
  endproperty
  a_unprot: assert property (p_unprot) else $error("unprotected denied");
  property p_secure;
    @(posedge clk_i) disable iff (rst_i)
      secure_r |-> (!debug_access_enable_o && debug_port_select_o == 2'(NVP_DBG_PORT_OFF));
  endproperty
  a_secure: assert property (p_secure) else $error("debug alive when secure");
  property p_fetch;
    @(posedge clk_i) disable iff (rst_i)
      (if_req_i && !if_eeprom_i) |-> if_grant_o;
  endproperty
  a_fetch: assert property (p_fetch) else $error("fetch stalled");
  property p_no_ee_fetch;
    @(posedge clk_i) disable iff (rst_i) if_eeprom_i |-> !if_grant_o;
  endproperty
  a_no_ee_fetch: assert property (p_no_ee_fetch) else $error("eeprom fetch");
  property p_prot_stable;
    @(posedge clk_i) disable iff (rst_i)
      (!erased_r && !erased_nxt) |-> (prot_nxt[row_sel] == prot_r[row_sel]);
  endproperty
  a_prot_stable: assert property (p_prot_stable) else $error("level changed");
  // flash access permission checks
  property p_factory_wr;
    @(posedge clk_i) disable iff (rst_i)
      (fl_req_i && fl_ext_i && fl_we_i && !secure_r && row_lvl == 2'(NVP_FACTORY))
        |-> !fl_deny_o;
  endproperty
  a_factory_wr: assert property (p_factory_wr) else $error("factory ext write denied");
  property p_full_rd;
    @(posedge clk_i) disable iff (rst_i)
      (fl_req_i && !fl_ext_i && !fl_we_i && row_lvl == 2'(NVP_FULL)) |-> !fl_deny_o;
  endproperty
  a_full_rd: assert property (p_full_rd) else $error("full prot read denied");
  property p_field_int;
    @(posedge clk_i) disable iff (rst_i)
      (fl_req_i && !fl_ext_i && row_lvl == 2'(NVP_FIELD)) |-> !fl_deny_o;
  endproperty
  a_field_int: assert property (p_field_int) else $error("field int denied");
  property p_secure_ext;
    @(posedge clk_i) disable iff (rst_i)
      (fl_req_i && fl_ext_i && secure_r) |-> fl_deny_o;
  endproperty
  a_secure_ext: assert property (p_secure_ext) else $error("ext access when secure");
  property p_secure_sticky;
    @(posedge clk_i) disable iff (rst_i)
      secure_r |=> secure_r;
  endproperty
  a_secure_sticky: assert property (p_secure_sticky) else $error("security undone");
  property p_grant_excl;
    @(posedge clk_i) disable iff (rst_i)
      !(fl_grant_o && fl_deny_o);
  endproperty
  a_grant_excl: assert property (p_grant_excl) else $error("grant with deny");
  // register side and nonvolatile write checks
  property p_busy_count;
    @(posedge clk_i) disable iff (rst_i)
      (busy_r != '0) |=> (busy_r == BUSY_W'($past(busy_r) - 1'b1));
  endproperty
  a_busy_count: assert property (p_busy_count) else $error("write timer jumped");
  property p_ee_commit;
    @(posedge clk_i) disable iff (rst_i)
      (ee_pend_r && busy_r == BUSY_W'(1))
        |=> (ee_r[{wr_row_r, 4'hF}] == $past(ebuf_r[NVP_EE_ROW_LEN-1]));
  endproperty
  a_ee_commit: assert property (p_ee_commit) else $error("row not committed");
  property p_ee_read;
    @(posedge clk_i) disable iff (rst_i)
      (rd_go && wb_adr_i == NVP_ADR_EE_DATA)
        |=> (wb_dat_o == {24'h0, $past(ee_r[ee_adr_r])});
  endproperty
  a_ee_read: assert property (p_ee_read) else $error("eeprom read data");
  property p_app_hold;
    @(posedge clk_i) disable iff (rst_i)
      app_done_r |=> ($stable(app_r[2]) && $stable(app_r[3]));
  endproperty
  a_app_hold: assert property (p_app_hold) else $error("config moved after reset");
  property p_latch_wr;
    @(posedge clk_i) disable iff (rst_i)
      (wr_go && busy_r == '0 && wb_adr_i == NVP_ADR_DRIVE_LOW)
        |=> (lat_r[0] == $past(wb_dat_i[7:0]));
  endproperty
  a_latch_wr: assert property (p_latch_wr) else $error("latch write lost");
  property p_rowprot_refused;
    @(posedge clk_i) disable iff (rst_i)
      (wr_go && wb_adr_i == NVP_ADR_ROWPROT && !erased_r)
        |-> (prot_nxt[wb_dat_i[15:8]] == prot_r[wb_dat_i[15:8]]);
  endproperty
  a_rowprot_refused: assert property (p_rowprot_refused) else $error("level set unerased");
  property p_ack_cause;
    @(posedge clk_i) disable iff (rst_i)
      ack_r |-> $past(wb_cyc_i && wb_stb_i);
  endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
  c_ee_write: cover property (@(posedge clk_i) ee_pend_r && busy_r == BUSY_W'(1));
  c_deny:     cover property (@(posedge clk_i) fl_deny_o);
  c_erase:    cover property (@(posedge clk_i) $rose(erased_r));
  c_secure:   cover property (@(posedge clk_i) $rose(secure_r));
  c_refused:  cover property (@(posedge clk_i) wr_go && busy_r != '0);
endmodule // nvp_top
`default_nettype wire

// ===== test/nvp_wb_host.sv
// wishbone host model: classic single-cycle register reads and writes
`timescale 1ns/100ps
`default_nettype none
module nvp_wb_host (
  // clock
  input  wire logic        clk_i,
  // wishbone master
  output logic             wb_cyc_o,
  output logic             wb_stb_o,
  output logic             wb_we_o,
  output logic [7:0]       wb_adr_o,
  output logic [3:0]       wb_sel_o,
  output logic [31:0]      wb_dat_o,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic        wb_ack_i
);
  initial
  begin
    {wb_cyc_o, wb_stb_o, wb_we_o, wb_adr_o, wb_sel_o, wb_dat_o} = '0;
  end
  // eeprom and latch writes only go through these register cycles
  task automatic xfer(input logic we, input logic [7:0] adr, input logic [31:0] dat,
                      output logic [31:0] rdat);
    @(posedge clk_i);
    wb_cyc_o <= 1'b1;
    wb_stb_o <= 1'b1;
    wb_we_o  <= we;
    wb_adr_o <= adr;
    wb_sel_o <= 4'hF;
    wb_dat_o <= dat;
    @(posedge clk_i);
    while (wb_ack_i !== 1'b1)
      @(posedge clk_i);
    rdat = wb_dat_i;
    wb_cyc_o <= 1'b0;
    wb_stb_o <= 1'b0;
    wb_we_o  <= 1'b0;
    // released bus shows inverted data so a stale value is never trusted
    wb_dat_o <= ~dat;
  endtask
endmodule // nvp_wb_host
`default_nettype wire

// ===== test/tb_nvp_top.sv
// testbench: latches, flash row protection, eeprom and security of nvp_top
`timescale 1ns/100ps
`default_nettype none
module tb_nvp_top;
  import nvp_pkg::*;
  logic clk_i = 1'b0, rst_i = 1'b1;
  logic wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, nv_busy_o;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic fl_req_i = 1'b0, fl_ext_i = 1'b0, fl_we_i = 1'b0, fl_grant_o, fl_deny_o;
  logic [15:0] fl_adr_i = 16'h0000, drv;
  logic if_req_i = 1'b0, if_eeprom_i = 1'b0, if_grant_o;
  logic [1:0] p15, dbg_port;
  logic ext_rst, dbg, ecc;
  logic [3:0] phs;
  int error_cnt = 0, checks_done = 0;
  always #50 clk_i = ~clk_i;
  nvp_top #(.WRITE_CYCLES(8)) dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .fl_req_i(fl_req_i),
    .fl_ext_i(fl_ext_i), .fl_we_i(fl_we_i), .fl_adr_i(fl_adr_i), .fl_grant_o(fl_grant_o),
    .fl_deny_o(fl_deny_o), .if_req_i(if_req_i), .if_eeprom_i(if_eeprom_i),
    .if_grant_o(if_grant_o), .port_reset_drive_field_o(drv), .port15_reset_drive_o(p15),
    .ext_reset_pin_enable_o(ext_rst), .debug_access_enable_o(dbg),
    .debug_port_select_o(dbg_port),
    .ecc_area_enable_o(ecc), .digital_clock_phase_delay_o(phs), .nv_busy_o(nv_busy_o));
  nvp_wb_host u_host (.clk_i(clk_i), .wb_cyc_o(wb_cyc_i), .wb_stb_o(wb_stb_i),
    .wb_we_o(wb_we_i), .wb_adr_o(wb_adr_i), .wb_sel_o(wb_sel_i), .wb_dat_o(wb_dat_i),
    .wb_dat_i(wb_dat_o), .wb_ack_i(wb_ack_o));
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(string name, logic [31:0] exp, logic [31:0] got);
    checks_done++;
    if (got !== exp)
    begin
      $display("CHECK FAILED %s expected %0h seen %0h", name, exp, got);
      error_cnt++;
    end
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d);
    logic [31:0] x;
    u_host.xfer(1'b1, a, d, x);
  endtask
  task automatic rd(string name, logic [7:0] a, logic [7:0] exp);
    logic [31:0] x;
    u_host.xfer(1'b0, a, 32'h0, x);
    chk(name, {24'h0, exp}, {24'h0, x[7:0]});
  endtask
  task automatic wait_idle();
    int n;
    n = 0;
    while (nv_busy_o !== 1'b0 && n < 100)
    begin
      @(posedge clk_i);
      n++;
    end
    chk("nv_busy_o", 0, nv_busy_o);
  endtask
  // short mid-run reset; writes are idle here so no nonvolatile cycle is cut
  task automatic do_reset();
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    @(negedge clk_i);
  endtask
  task automatic cfg_chk(logic [7:0] b0, logic [7:0] b1, logic [7:0] b2, logic [7:0] b3);
    chk("config", {b1, b0, b2[1:0], b2[NVP_F_EXT_RST_EN], b2[NVP_F_DBG_EN],
        b3[NVP_F_DBG_PORT_LSB+:2], b3[NVP_F_ECC_EN], b3[NVP_F_PHS_LSB+:4]},
        {drv, p15, ext_rst, dbg, dbg_port, ecc, phs});
  endtask
  function automatic logic allowed(int lvl, logic ext, logic we);
    case (lvl)
      0:       return 1'b1;
      1:       return ext ? we : 1'b1;
      2:       return !ext;
      default: return !ext && !we;
    endcase
  endfunction
  task automatic fl_chk(int lvl, logic ext, logic we);
    @(posedge clk_i);
    fl_req_i <= 1'b1;
    fl_ext_i <= ext;
    fl_we_i  <= we;
    fl_adr_i <= {8'(lvl + 1), 8'h3C};
    @(negedge clk_i);
    chk("fl_grant_o", allowed(lvl, ext, we), fl_grant_o);
    chk("fl_deny_o", !allowed(lvl, ext, we), fl_deny_o);
  endtask
  initial
  begin
    #1_000_000;
    error_cnt++;
    wrap_up();
  end
  initial
  begin
    logic [7:0] b0, b2, b3;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    @(negedge clk_i);
    cfg_chk(NVP_RST_DRIVE_LOW, NVP_RST_DRIVE_HIGH, NVP_RST_RST_DBG, NVP_RST_CLK_ECC);
    rd("latch2", NVP_ADR_RST_DBG, NVP_RST_RST_DBG);
    rd("latch3", NVP_ADR_CLK_ECC, NVP_RST_CLK_ECC);
    rd("unmapped", 8'h40, 8'h00);
    $display("test defaults done");
    for (int k = 3; k >= 0; k--)
    begin
      b0 = {4{2'(k)}};
      b2 = {k[0], !k[0], 4'h0, 2'(k)};
      b3 = {4'(k), k[0], 2'(k), 1'b0};
      wr(NVP_ADR_DRIVE_LOW, b0);
      wr(NVP_ADR_DRIVE_HIGH, ~b0);
      wr(NVP_ADR_RST_DBG, b2);
      wr(NVP_ADR_CLK_ECC, b3);
      wait_idle();
      rd("latch0", NVP_ADR_DRIVE_LOW, b0);
      do_reset();
      cfg_chk(b0, ~b0, b2, b3);
    end
    wr(NVP_ADR_CTRL, 32'h1 << NVP_CTRL_LATCH_COMMIT);
    @(negedge clk_i);
    chk("nv_busy_o", 1, nv_busy_o);
    wait_idle();
    $display("test latches done");
    wr(NVP_ADR_CTRL, 32'h1 << NVP_CTRL_CHIP_ERASE);
    wait_idle();
    rd("status", NVP_ADR_STATUS, 8'h04);
    for (int l = 0; l < 4; l++)
    begin
      wr(NVP_ADR_ROWPROT, {16'h0, 8'(l + 1), 6'h0, 2'(l)});
      wait_idle();
    end
    wr(NVP_ADR_ROWPROT, {16'h0, 8'h02, 8'h03});
    wait_idle();
    for (int l = 0; l < 4; l++)
      for (int e = 0; e < 4; e++)
        fl_chk(l, e[1], e[0]);
    @(posedge clk_i);
    fl_req_i <= 1'b0;
    $display("test protection done");
    for (int i = 0; i < NVP_EE_ROW_LEN; i++)
    begin
      wr(NVP_ADR_EE_ADDR, 32'h50 + i);
      wr(NVP_ADR_EE_DATA, 32'hA0 + i);
    end
    wr(NVP_ADR_CTRL, 32'h1 << NVP_CTRL_EE_WRITE);
    @(negedge clk_i);
    chk("nv_busy_o", 1, nv_busy_o);
    wr(NVP_ADR_DRIVE_LOW, 32'hFF);
    if_req_i <= 1'b1;
    @(negedge clk_i);
    chk("if_grant_o", 1, if_grant_o);
    @(posedge clk_i);
    if_eeprom_i <= 1'b1;
    @(negedge clk_i);
    chk("if_grant_o", 0, if_grant_o);
    wait_idle();
    rd("refused latch", NVP_ADR_DRIVE_LOW, 8'h00);
    for (int i = 0; i < NVP_EE_ROW_LEN; i++)
    begin
      wr(NVP_ADR_EE_ADDR, 32'h50 + i);
      rd("eeprom", NVP_ADR_EE_DATA, 8'hA0 + 8'(i));
    end
    rd("ee_addr", NVP_ADR_EE_ADDR, 8'h5F);
    $display("test eeprom done");
    wr(NVP_ADR_CTRL, 32'h1 << NVP_CTRL_SECURE);
    wait_idle();
    do_reset();
    chk("debug_access_enable_o", 0, dbg);
    chk("debug_port_select_o", NVP_DBG_PORT_OFF, dbg_port);
    rd("status", NVP_ADR_STATUS, 8'h02);
    wr(NVP_ADR_ROWPROT, {16'h0, 8'h01, 8'h03});
    fl_chk(0, 1'b0, 1'b1);
    @(posedge clk_i);
    fl_ext_i <= 1'b1;
    fl_we_i  <= 1'b0;
    @(negedge clk_i);
    chk("fl_deny_o", 1, fl_deny_o);
    $display("test security done");
    wrap_up();
  end
endmodule // tb_nvp_top
`default_nettype wire
